// *** rtd_pkg.sv ***
/*
 * Constants for the run control and transfer engine: register offsets,
 * command and status bit positions, buffer kind and direction codes.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package rtd_pkg;

    // Register byte offsets
    localparam logic [19:0] RTD_OFF_CMD      = 20'h0_0000;
    localparam logic [19:0] RTD_OFF_STATUS   = 20'h0_0004;
    localparam logic [19:0] RTD_OFF_MODE     = 20'h0_0008;
    localparam logic [19:0] RTD_OFF_CAPLEN   = 20'h0_000c;
    localparam logic [19:0] RTD_OFF_PRELEN   = 20'h0_0010;
    localparam logic [19:0] RTD_OFF_POSTLEN  = 20'h0_0014;
    localparam logic [19:0] RTD_OFF_KIND     = 20'h0_0018;
    localparam logic [19:0] RTD_OFF_DIR      = 20'h0_001c;
    localparam logic [19:0] RTD_OFF_NOTIFY   = 20'h0_0020;
    localparam logic [19:0] RTD_OFF_HOSTPTR  = 20'h0_0024;
    localparam logic [19:0] RTD_OFF_BRDOFF   = 20'h0_0028;
    localparam logic [19:0] RTD_OFF_XLEN     = 20'h0_002c;
    localparam logic [19:0] RTD_OFF_XDONE    = 20'h0_0030;
    localparam logic [19:0] RTD_OFF_MEMCHECK = 20'h3_0ffc;

    // Command bit positions
    localparam int RTD_CMD_LAUNCH   = 2;
    localparam int RTD_CMD_ARM      = 3;
    localparam int RTD_CMD_DISARM   = 5;
    localparam int RTD_CMD_STOP     = 6;
    localparam int RTD_CMD_XSTART   = 16;
    localparam int RTD_CMD_XSTOP    = 18;

    // Status bit positions
    localparam int RTD_ST_PREFULL   = 0;
    localparam int RTD_ST_TRIGSEEN  = 1;
    localparam int RTD_ST_RUNDONE   = 2;
    localparam int RTD_ST_BLKREADY  = 8;
    localparam int RTD_ST_XEND      = 9;
    localparam int RTD_ST_XERROR    = 11;
    localparam int RTD_ST_XBUSY     = 12;
    localparam int RTD_ST_BUFVALID  = 13;

    // Buffer kind codes
    localparam logic [31:0] RTD_KIND_SAMPLE = 32'd1000;
    localparam logic [31:0] RTD_KIND_SIDE   = 32'd2000;
    localparam logic [31:0] RTD_KIND_STAMP  = 32'd3000;

    // Direction codes
    localparam logic [1:0] RTD_DIR_H2B = 2'd0;
    localparam logic [1:0] RTD_DIR_B2H = 2'd1;
    localparam logic [1:0] RTD_DIR_B2A = 2'd2;
    localparam logic [1:0] RTD_DIR_A2B = 2'd3;

    // Transfer granularity and limits
    localparam logic [31:0] RTD_PAGE_BYTES  = 32'h0000_1000;
    localparam logic [31:0] RTD_SIDE_MIN    = 32'h0000_0800;
    localparam logic [31:0] RTD_WORD_BYTES  = 32'h0000_0004;

    // Reset values
    localparam logic [31:0] RTD_RST_ZERO    = 32'h0000_0000;

endpackage : rtd_pkg

// *** rtd_core.sv ***
/*
 * Run sequencer and host transfer engine with its APB register file.
 * Assumes samples are paced by sample_tick_i, trigger events arrive on
 * trigger_i, and an outside mover moves one 32-bit word per ack.
 */
// Behaviour
// - Acquisition launch fills pre-window, then sets pre-full flag
// - Trigger looked for only after arm command
// - Acquisition trigger sets seen flag, records post samples
// - After post samples, run-done flag is set
// - Generation launch goes straight to trigger wait, disarmed unless armed too, without replaying
// - Generation trigger sets seen flag, starts replay
// - Replay end sets run-done and stops output
// - Run and transfer share command and status
// - Buffer defined first, used once, then invalidated
// - Kind 1000 sample, 2000 side, 3000 stamp
// - Direction 0/1/2/3: h2b, b2h, b2a, a2b
// - Direction must match mode unless memory check
// - Notify events per count, or once at end
// - Board offset sets transfer start in memory
// - Board-to-host overwrites host buffer with memory
// - Memory check mode: free access, run commands ignored
// - Status bits 1h, 2h, 4h report run progress
`timescale 1ns/10ps
module rtd_core
    import rtd_pkg::*;
#(
    parameter int AW = 32
) (
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [19:0]   paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic          sample_tick_i,
    input  wire logic          trigger_i,
    output logic               replay_active_o,
    output logic               mover_req_o,
    output logic      [1:0]    mover_dir_o,
    output logic      [1:0]    mover_kind_o,
    output logic      [AW-1:0] mover_host_addr_o,
    output logic      [AW-1:0] mover_board_addr_o,
    input  wire logic          mover_ack_i
);

    typedef enum logic [5:0] {
        RS_IDLE   = 6'b00_0001,
        RS_PRE    = 6'b00_0010,
        RS_WAIT   = 6'b00_0100,
        RS_POST   = 6'b00_1000,
        RS_REPLAY = 6'b01_0000,
        RS_DONE   = 6'b10_0000
    } rtd_run_t;

    typedef enum logic [1:0] {
        XS_IDLE = 2'b01,
        XS_MOVE = 2'b10
    } rtd_xfer_t;

    rtd_run_t    run_q;
    rtd_xfer_t   xfer_q;
    logic        gen_mode_q;
    logic        memcheck_q;
    logic        trig_en_q;
    logic        pre_full_q;
    logic        trig_seen_q;
    logic        run_done_q;
    logic        blk_ready_q;
    logic        xend_q;
    logic        xerr_q;
    logic        buf_valid_q;
    logic [31:0] cap_len_q;
    logic [31:0] pre_len_q;
    logic [31:0] post_len_q;
    logic [31:0] kind_q;
    logic [1:0]  dir_q;
    logic [31:0] notify_q;
    logic [31:0] host_ptr_q;
    logic [31:0] brd_off_q;
    logic [31:0] xlen_q;
    logic [31:0] xdone_q;
    logic [31:0] nbytes_q;
    logic [31:0] sample_cnt_q;

    // Bus qualifiers: effect at the edge where pready is seen high
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rdata;
    logic [31:0] status;
    assign acc = psel_i & penable_i & pready_o;
    assign wr  = acc & pwrite_i & ~pslverr_o;

    // Command pulses, run commands masked in memory check mode
    logic cmd_wr;
    logic c_launch;
    logic c_arm;
    logic c_disarm;
    logic c_stop;
    logic c_xstart;
    logic c_xstop;
    assign cmd_wr   = wr & (paddr_i == RTD_OFF_CMD);
    assign c_launch = cmd_wr & pwdata_i[RTD_CMD_LAUNCH] & ~memcheck_q;
    assign c_arm    = cmd_wr & pwdata_i[RTD_CMD_ARM] & ~memcheck_q;
    assign c_disarm = cmd_wr & pwdata_i[RTD_CMD_DISARM] & ~memcheck_q;
    assign c_stop   = cmd_wr & pwdata_i[RTD_CMD_STOP] & ~memcheck_q;
    assign c_xstart = cmd_wr & pwdata_i[RTD_CMD_XSTART];
    assign c_xstop  = cmd_wr & pwdata_i[RTD_CMD_XSTOP];

    // Notify count legality per buffer kind
    function automatic logic notify_ok(input logic [31:0] kind, input logic [31:0] n);
        logic frac;
        logic page;
        frac = (n == 32'h0000_0010) || (n == 32'h0000_0020) || (n == 32'h0000_0040)
            || (n == 32'h0000_0080) || (n == 32'h0000_0100) || (n == 32'h0000_0200)
            || (n == 32'h0000_0400) || (n == 32'h0000_0800);
        page = (n[11:0] == 12'h000);
        if (n == RTD_RST_ZERO) begin
            notify_ok = 1'b1;
        end else if (kind == RTD_KIND_SAMPLE) begin
            notify_ok = frac | page;
        end else begin
            notify_ok = (n >= RTD_SIDE_MIN) & ((n == RTD_SIDE_MIN) | page);
        end
    endfunction : notify_ok

    // Start legality: defined buffer, kind, direction, mode, length
    logic kind_ok;
    logic dir_ok;
    logic len_ok;
    logic start_ok;
    assign kind_ok = (kind_q == RTD_KIND_SAMPLE) | (kind_q == RTD_KIND_SIDE)
                   | (kind_q == RTD_KIND_STAMP);
    assign dir_ok  = memcheck_q
                   | ((dir_q == RTD_DIR_H2B) & gen_mode_q)
                   | ((dir_q == RTD_DIR_B2H) & ~gen_mode_q)
                   | ((dir_q == RTD_DIR_B2A) & ~gen_mode_q)
                   | ((dir_q == RTD_DIR_A2B) & gen_mode_q);
    assign len_ok  = (xlen_q != RTD_RST_ZERO) & (xlen_q[1:0] == 2'b00)
                   & (xlen_q <= cap_len_q);
    assign start_ok = buf_valid_q & kind_ok & dir_ok & len_ok
                    & notify_ok(kind_q, notify_q);

    logic word_done;
    logic last_word;
    logic nbytes_hit;
    assign word_done  = (xfer_q == XS_MOVE) & mover_req_o & mover_ack_i;
    assign last_word  = (xdone_q + RTD_WORD_BYTES) == xlen_q;
    assign nbytes_hit = (notify_q != RTD_RST_ZERO)
                      & ((nbytes_q + RTD_WORD_BYTES) == notify_q);

    // APB ready with one wait state, error on unmapped address
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= RTD_RST_ZERO;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
            if (psel_i & penable_i & ~pready_o) begin
                prdata_o <= rdata;
            end
        end
    end

    // Read mux and address decode
    always_comb begin
        status = RTD_RST_ZERO;
        status[RTD_ST_PREFULL]  = pre_full_q;
        status[RTD_ST_TRIGSEEN] = trig_seen_q;
        status[RTD_ST_RUNDONE]  = run_done_q;
        status[RTD_ST_BLKREADY] = blk_ready_q;
        status[RTD_ST_XEND]     = xend_q;
        status[RTD_ST_XERROR]   = xerr_q;
        status[RTD_ST_XBUSY]    = (xfer_q == XS_MOVE);
        status[RTD_ST_BUFVALID] = buf_valid_q;
        hit   = 1'b1;
        rdata = RTD_RST_ZERO;
        if (paddr_i == RTD_OFF_CMD) begin
            rdata = RTD_RST_ZERO;
        end else if (paddr_i == RTD_OFF_STATUS) begin
            rdata = status;
        end else if (paddr_i == RTD_OFF_MODE) begin
            rdata = {31'h0000_0000, gen_mode_q};
        end else if (paddr_i == RTD_OFF_CAPLEN) begin
            rdata = cap_len_q;
        end else if (paddr_i == RTD_OFF_PRELEN) begin
            rdata = pre_len_q;
        end else if (paddr_i == RTD_OFF_POSTLEN) begin
            rdata = post_len_q;
        end else if (paddr_i == RTD_OFF_KIND) begin
            rdata = kind_q;
        end else if (paddr_i == RTD_OFF_DIR) begin
            rdata = {30'h0000_0000, dir_q};
        end else if (paddr_i == RTD_OFF_NOTIFY) begin
            rdata = notify_q;
        end else if (paddr_i == RTD_OFF_HOSTPTR) begin
            rdata = host_ptr_q;
        end else if (paddr_i == RTD_OFF_BRDOFF) begin
            rdata = brd_off_q;
        end else if (paddr_i == RTD_OFF_XLEN) begin
            rdata = xlen_q;
        end else if (paddr_i == RTD_OFF_XDONE) begin
            rdata = xdone_q;
        end else if (paddr_i == RTD_OFF_MEMCHECK) begin
            rdata = {31'h0000_0000, memcheck_q};
        end else begin
            hit = 1'b0;
        end
    end

    // Setup registers written by software
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gen_mode_q <= 1'b0;
            memcheck_q <= 1'b0;
            cap_len_q  <= RTD_RST_ZERO;
            pre_len_q  <= RTD_RST_ZERO;
            post_len_q <= RTD_RST_ZERO;
            kind_q     <= RTD_RST_ZERO;
            dir_q      <= RTD_DIR_H2B;
            notify_q   <= RTD_RST_ZERO;
            host_ptr_q <= RTD_RST_ZERO;
            brd_off_q  <= RTD_RST_ZERO;
            xlen_q     <= RTD_RST_ZERO;
        end else if (wr) begin
            if (paddr_i == RTD_OFF_MODE) begin
                gen_mode_q <= pwdata_i[0];
            end else if (paddr_i == RTD_OFF_MEMCHECK) begin
                memcheck_q <= pwdata_i[0];
            end else if (paddr_i == RTD_OFF_CAPLEN) begin
                cap_len_q <= pwdata_i;
            end else if (paddr_i == RTD_OFF_PRELEN) begin
                pre_len_q <= pwdata_i;
            end else if (paddr_i == RTD_OFF_POSTLEN) begin
                post_len_q <= pwdata_i;
            end else if (paddr_i == RTD_OFF_KIND) begin
                kind_q <= pwdata_i;
            end else if (paddr_i == RTD_OFF_DIR) begin
                dir_q <= pwdata_i[1:0];
            end else if (paddr_i == RTD_OFF_NOTIFY) begin
                notify_q <= pwdata_i;
            end else if (paddr_i == RTD_OFF_HOSTPTR) begin
                host_ptr_q <= {pwdata_i[31:12], 12'h000};
            end else if (paddr_i == RTD_OFF_BRDOFF) begin
                brd_off_q <= pwdata_i;
            end else if (paddr_i == RTD_OFF_XLEN) begin
                xlen_q <= pwdata_i;
            end
        end
    end

    // Trigger detection enable: launch starts disarmed unless armed too
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_en_q <= 1'b0;
        end else if (c_arm) begin
            trig_en_q <= 1'b1;
        end else if (c_launch | c_disarm | c_stop) begin
            trig_en_q <= 1'b0;
        end
    end

    // Run sequencer for acquisition and generation
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_q           <= RS_IDLE;
            sample_cnt_q    <= RTD_RST_ZERO;
            replay_active_o <= 1'b0;
        end else if (c_stop) begin
            run_q           <= RS_IDLE;
            replay_active_o <= 1'b0;
        end else if (c_launch) begin
            run_q           <= gen_mode_q ? RS_WAIT : RS_PRE;
            sample_cnt_q    <= RTD_RST_ZERO;
            replay_active_o <= 1'b0;
        end else begin
            case (run_q)
                RS_PRE: begin
                    if (sample_cnt_q >= pre_len_q) begin
                        run_q <= RS_WAIT;
                    end else if (sample_tick_i) begin
                        sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
                    end
                end
                RS_WAIT: begin
                    if ((trig_en_q | c_arm) & trigger_i) begin
                        run_q           <= gen_mode_q ? RS_REPLAY : RS_POST;
                        replay_active_o <= gen_mode_q;
                        sample_cnt_q    <= RTD_RST_ZERO;
                    end
                end
                RS_POST, RS_REPLAY: begin
                    if (sample_cnt_q >= post_len_q) begin
                        run_q           <= RS_DONE;
                        replay_active_o <= 1'b0;
                    end else if (sample_tick_i) begin
                        sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
                    end
                end
                default: begin
                    run_q <= run_q;
                end
            endcase
        end
    end

    // Run progress flags, cleared by launch, set wins the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_full_q  <= 1'b0;
            trig_seen_q <= 1'b0;
            run_done_q  <= 1'b0;
        end else begin
            if ((run_q == RS_PRE) & (sample_cnt_q >= pre_len_q) & ~c_stop) begin
                pre_full_q <= 1'b1;
            end else if (c_launch) begin
                pre_full_q <= 1'b0;
            end
            if ((run_q == RS_WAIT) & (trig_en_q | c_arm) & trigger_i & ~c_stop) begin
                trig_seen_q <= 1'b1;
            end else if (c_launch) begin
                trig_seen_q <= 1'b0;
            end
            if (((run_q == RS_POST) | (run_q == RS_REPLAY)) & (sample_cnt_q >= post_len_q)
                & ~c_stop) begin
                run_done_q <= 1'b1;
            end else if (c_launch) begin
                run_done_q <= 1'b0;
            end
        end
    end

    // Buffer definition: committed by length write, consumed by one transfer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_valid_q <= 1'b0;
        end else if (word_done & last_word) begin
            buf_valid_q <= 1'b0;
        end else if (c_xstop & (xfer_q == XS_MOVE)) begin
            buf_valid_q <= 1'b0;
        end else if (wr & (paddr_i == RTD_OFF_XLEN)) begin
            buf_valid_q <= 1'b1;
        end
    end

    // Transfer engine: one word per mover handshake
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xfer_q             <= XS_IDLE;
            mover_req_o        <= 1'b0;
            mover_dir_o        <= RTD_DIR_H2B;
            mover_kind_o       <= 2'b00;
            mover_host_addr_o  <= '0;
            mover_board_addr_o <= '0;
            xdone_q            <= RTD_RST_ZERO;
            nbytes_q           <= RTD_RST_ZERO;
        end else if (xfer_q == XS_IDLE) begin
            if (c_xstart & start_ok) begin
                xfer_q             <= XS_MOVE;
                mover_req_o        <= 1'b1;
                mover_dir_o        <= dir_q;
                mover_kind_o       <= kind_q[11:10] + 2'd1;
                mover_host_addr_o  <= AW'(host_ptr_q);
                mover_board_addr_o <= AW'(brd_off_q);
                xdone_q            <= RTD_RST_ZERO;
                nbytes_q           <= RTD_RST_ZERO;
            end
        end else if (c_xstop) begin
            xfer_q      <= XS_IDLE;
            mover_req_o <= 1'b0;
        end else if (word_done) begin
            xdone_q            <= xdone_q + RTD_WORD_BYTES;
            mover_host_addr_o  <= mover_host_addr_o + AW'(RTD_WORD_BYTES);
            mover_board_addr_o <= mover_board_addr_o + AW'(RTD_WORD_BYTES);
            nbytes_q           <= nbytes_hit ? RTD_RST_ZERO : nbytes_q + RTD_WORD_BYTES;
            if (last_word) begin
                xfer_q      <= XS_IDLE;
                mover_req_o <= 1'b0;
            end
        end
    end

    // Transfer event flags, cleared by a transfer start, set wins
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blk_ready_q <= 1'b0;
            xend_q      <= 1'b0;
            xerr_q      <= 1'b0;
        end else begin
            if (word_done & ~c_xstop & (nbytes_hit | (last_word & (notify_q != 0)))) begin
                blk_ready_q <= 1'b1;
            end else if (c_xstart & (xfer_q == XS_IDLE)) begin
                blk_ready_q <= 1'b0;
            end
            if (word_done & ~c_xstop & last_word & (notify_q == RTD_RST_ZERO)) begin
                xend_q <= 1'b1;
            end else if (c_xstart & (xfer_q == XS_IDLE)) begin
                xend_q <= 1'b0;
            end
            if (c_xstart & (xfer_q == XS_IDLE) & ~start_ok) begin
                xerr_q <= 1'b1;
            end else if (c_xstart & (xfer_q == XS_IDLE)) begin
                xerr_q <= 1'b0;
            end
        end
    end

endmodule : rtd_core

// *** rtd_core_properties.sv ***
/* Port checker for rtd_core: bus answer timing, trigger cause, mover stepping.
   Assumes it is bound onto rtd_core and shares its AW parameter. */
`timescale 1ns/10ps
module rtd_core_props #(
    parameter int AW = 32
) (
    input wire logic          clk_i,
    input wire logic          rstn_i,
    input wire logic          psel_i,
    input wire logic          penable_i,
    input wire logic [31:0]   prdata_o,
    input wire logic          pready_o,
    input wire logic          pslverr_o,
    input wire logic          trigger_i,
    input wire logic          replay_active_o,
    input wire logic          mover_req_o,
    input wire logic          mover_ack_i,
    input wire logic [1:0]    mover_dir_o,
    input wire logic [AW-1:0] mover_host_addr_o,
    input wire logic [AW-1:0] mover_board_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Bus answer shape
    a_ready_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready not after one wait state");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_zero_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0000_0000)
        else $error("error answer malformed");
    // Replay only follows a trigger
    a_replay_cause: assert property ($rose(replay_active_o) |-> $past(trigger_i))
        else $error("replay started without trigger");
    // Mover addressing and direction
    a_page_start: assert property ($rose(mover_req_o) |-> mover_host_addr_o[11:0] == 12'h000)
        else $error("host address not page aligned");
    a_addr_step: assert property (mover_req_o && mover_ack_i |=> !mover_req_o ||
        (mover_board_addr_o == $past(mover_board_addr_o) + 4 &&
         mover_host_addr_o == $past(mover_host_addr_o) + 4))
        else $error("address did not step by a word");
    a_addr_hold: assert property (mover_req_o && !mover_ack_i |=> !mover_req_o ||
        $stable(mover_board_addr_o))
        else $error("address moved without ack");
    a_dir_hold: assert property (mover_req_o && $past(mover_req_o) |-> $stable(mover_dir_o))
        else $error("direction changed mid transfer");
    c_err: cover property (pslverr_o);
    c_replay: cover property ($rose(replay_active_o));
    c_xfer: cover property ($fell(mover_req_o));
endmodule : rtd_core_props
bind rtd_core rtd_core_props #(.AW(AW)) u_props (.clk_i(clk_i), .rstn_i(rstn_i),
    .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .trigger_i(trigger_i), .replay_active_o(replay_active_o),
    .mover_req_o(mover_req_o), .mover_ack_i(mover_ack_i), .mover_dir_o(mover_dir_o),
    .mover_host_addr_o(mover_host_addr_o), .mover_board_addr_o(mover_board_addr_o));

// *** rtd_mover_model.sv ***
/* Far-side word mover: acks requested words, promptly or every other cycle.
   Assumes one word moves per cycle with request and ack both high. */
`timescale 1ns/10ps
module rtd_mover_model (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic req_i,
    input  wire logic slow_i,
    output logic      ack_o
);
    logic stall_q;
    // Ack follows request, stalling alternate cycles when slow
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stall_q <= 1'b0;
            ack_o   <= 1'b0;
        end else begin
            stall_q <= slow_i && !stall_q;
            ack_o   <= req_i && !(slow_i && !stall_q);
        end
    end
endmodule : rtd_mover_model

// *** testbench.sv ***
/* Self-checking bench for rtd_core: runs, transfers, refusals, memory check.
   Assumes the mover model on the far side and bench-paced sample ticks. */
`timescale 1ns/10ps
module testbench;
    import rtd_pkg::*;
    logic        clk_i, rstn_i, psel, penable, pwrite, tick, trig, ack, slow, err_v;
    logic        pready, pslverr, replay, req;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, haddr, baddr;
    logic [1:0]  mdir, mkind;
    int          num_errors, comparisons, post, boff;
    rtd_core dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sample_tick_i(tick), .trigger_i(trig),
        .replay_active_o(replay), .mover_req_o(req), .mover_dir_o(mdir),
        .mover_kind_o(mkind), .mover_host_addr_o(haddr), .mover_board_addr_o(baddr),
        .mover_ack_i(ack));
    rtd_mover_model host (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .slow_i(slow),
        .ack_o(ack));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    function automatic logic [31:0] run_st(input logic p, input logic t, input logic d);
        return {29'h0, d, t, p};
    endfunction : run_st
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 40);
        rd_v = prdata;
        err_v = pslverr;
        chk({31'h0, pready}, 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_v & m, e);
    endtask : rd
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
        end
    endtask : ticks
    task automatic pulse_trig();
        trig <= 1'b1;
        repeat (2) @(posedge clk_i);
        trig <= 1'b0;
    endtask : pulse_trig
    // Defines a buffer, starts it and follows it to the end, or checks its refusal
    task automatic xfer(input logic [31:0] kind, input logic [1:0] dir,
                        input logic [31:0] ntf, input logic [31:0] ln, input logic ok);
        int n;
        n = 0;
        boff = $urandom_range(0, 255) * 4;
        slow <= 1'($urandom_range(0, 1));
        wr(RTD_OFF_KIND, kind);
        wr(RTD_OFF_DIR, {30'h0, dir});
        wr(RTD_OFF_NOTIFY, ntf);
        wr(RTD_OFF_HOSTPTR, $urandom & 32'hFFFF_F000);
        wr(RTD_OFF_BRDOFF, boff);
        wr(RTD_OFF_XLEN, ln);
        wr(RTD_OFF_CMD, 32'h0001_0000);
        while (req !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        chk({31'h0, req}, {31'h0, ok});
        if (ok) begin
            chk(baddr, 32'(boff));
            chk({30'h0, mdir}, {30'h0, dir});
            chk({30'h0, mkind}, kind / 1000);
            while (req === 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
            rd(RTD_OFF_XDONE, 32'hFFFF_FFFF, ln);
            rd(RTD_OFF_STATUS, 32'h0000_3B00, ntf == 0 ? 32'h0000_0200 : 32'h0000_0100);
        end else begin
            rd(RTD_OFF_STATUS, 32'h0000_0800, 32'h0000_0800);
        end
    endtask : xfer
    task automatic close_out();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // Watchdog
    initial begin
        #2000000;
        num_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        void'($urandom(95));
        {psel, penable, pwrite, tick, trig, slow, rstn_i} = '0;
        paddr = '0;
        pwdata = '0;
        num_errors = 0;
        comparisons = 0;
        post = $urandom_range(2, 6);
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(RTD_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 20'h0_0ff0, 32'h0000_0000);
        chk({31'h0, err_v}, 32'h0000_0001);
        wr(RTD_OFF_MODE, 32'h0000_0000);
        wr(RTD_OFF_PRELEN, 32'h0000_0003);
        wr(RTD_OFF_POSTLEN, post);
        wr(RTD_OFF_CMD, 32'h0000_0004);
        ticks(4);
        pulse_trig();
        rd(RTD_OFF_STATUS, 32'h7, run_st(1, 0, 0));
        wr(RTD_OFF_CMD, 32'h0000_0008);
        pulse_trig();
        rd(RTD_OFF_STATUS, 32'h7, run_st(1, 1, 0));
        ticks(post + 1);
        rd(RTD_OFF_STATUS, 32'h7, run_st(1, 1, 1));
        wr(RTD_OFF_MODE, 32'h0000_0001);
        wr(RTD_OFF_CMD, 32'h0000_000c);
        ticks(3);
        chk({31'h0, replay}, 32'h0000_0000);
        pulse_trig();
        chk({31'h0, replay}, 32'h0000_0001);
        ticks(post + 1);
        rd(RTD_OFF_STATUS, 32'h7, run_st(0, 1, 1));
        chk({31'h0, replay}, 32'h0000_0000);
        wr(RTD_OFF_MEMCHECK, 32'h0000_0001);
        wr(RTD_OFF_CMD, 32'h0000_0004);
        rd(RTD_OFF_STATUS, 32'h7, run_st(0, 1, 1));
        wr(RTD_OFF_CAPLEN, 32'h0000_0100);
        xfer(RTD_KIND_SAMPLE, RTD_DIR_B2H, 0, 16, 1'b1);
        wr(RTD_OFF_MEMCHECK, 32'h0000_0000);
        xfer(RTD_KIND_SAMPLE, RTD_DIR_B2H, 0, 16, 1'b0);
        xfer(RTD_KIND_SAMPLE, RTD_DIR_H2B, 16, 32, 1'b1);
        xfer(RTD_KIND_SAMPLE, RTD_DIR_A2B, 0, 8, 1'b1);
        wr(RTD_OFF_CMD, 32'h0001_0000);
        rd(RTD_OFF_STATUS, 32'h0000_2800, 32'h0000_0800);
        wr(RTD_OFF_MODE, 32'h0000_0000);
        for (int k = 1; k <= 3; k++) begin
            xfer(k * 1000, k[0] ? RTD_DIR_B2H : RTD_DIR_B2A, 0, $urandom_range(1, 64) * 4,
                 1'b1);
        end
        xfer(RTD_KIND_SAMPLE, RTD_DIR_B2H, 48, 16, 1'b0);
        xfer(RTD_KIND_SIDE, RTD_DIR_B2H, 1024, 16, 1'b0);
        xfer(RTD_KIND_SAMPLE, RTD_DIR_B2H, 0, 260, 1'b0);
        close_out();
    end
endmodule : testbench
